// *** core/mac_tx_pkg.sv ***
package mac_tx_pkg;
   // Transmit buffer geometry and levels (depth must be a power of two)
   localparam int BUF_DEPTH       = 32;
   localparam int BUF_HIGH_LEVEL  = 24;
   localparam int BUF_START_LEVEL = 16;
   // Serial lane layout
   localparam int LANES           = 4;
   localparam int LANE_W          = 16;
   localparam logic [15:0] MARKER_WORD = 16'h4d3c;
   // Alignment marker spacing in line words
   localparam int AM_SPACING      = 16383;
   // High error rate: bit error ratio of one in BER_DEN
   localparam int BER_DEN         = 10000;
   localparam int BER_WINDOW      = 8192;
   // Pin synchroniser depth
   localparam int SYNC_STAGES     = 3;

   typedef enum logic [1:0] {
      LINE_IDLE,
      LINE_SEND,
      LINE_DROP
   } line_state_t;
endpackage : mac_tx_pkg

// *** core/lane_if.sv ***
`timescale 1ns/10ps
interface lane_if #(
   parameter int W = 16
);
   logic [W-1:0] data;
   logic         par;
   logic         valid;
   logic         err;

   modport src (output data, output par, output valid, input err);
   modport chk (input data, input par, input valid, output err);
endinterface : lane_if

// *** core/lane_parity_check.sv ***
`timescale 1ns/10ps
module lane_parity_check (
   input wire logic clk,
   input wire logic rstn,
   lane_if.chk      lane
);
   logic next_err;

   always_comb begin
      // Even parity over data and parity bit; odd sum is a lane error
      next_err = lane.valid && (^{lane.par, lane.data});
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lane.err <= 1'b0;
      end else begin
         lane.err <= next_err;
      end
   end
endmodule : lane_parity_check

// *** core/hi_ber_monitor.sv ***
`timescale 1ns/10ps
module hi_ber_monitor #(
   parameter int LANES  = mac_tx_pkg::LANES,
   parameter int WINDOW = mac_tx_pkg::BER_WINDOW,
   parameter int LIMIT  = WINDOW * LANES * mac_tx_pkg::LANE_W
                          / mac_tx_pkg::BER_DEN
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [LANES-1:0] lane_err,
   output logic                  high_rate
);
   localparam int TW = $clog2(WINDOW);
   localparam int EW = $clog2(WINDOW * LANES + 1);

   logic [TW-1:0] tick;
   logic [TW-1:0] next_tick;
   logic [EW-1:0] errs;
   logic [EW-1:0] next_errs;
   logic          next_high_rate;
   logic [EW-1:0] sum;

   always_comb begin
      sum = errs;
      for (int i = 0; i < LANES; i++) begin
         sum = EW'(sum + EW'(lane_err[i]));
      end
      next_high_rate = high_rate;
      next_errs      = sum;
      next_tick      = TW'(tick + TW'(1));
      if (tick == TW'(WINDOW - 1)) begin
         // Verdict for the closing window, held through the next one
         next_high_rate = sum > EW'(LIMIT);
         next_errs      = '0;
         next_tick      = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick      <= '0;
         errs      <= '0;
         high_rate <= 1'b0;
      end else begin
         tick      <= next_tick;
         errs      <= next_errs;
         high_rate <= next_high_rate;
      end
   end
endmodule : hi_ber_monitor

// *** core/mac_tx_flow_and_diagnostics.sv ***
// Functional notes
// - tx_buffer_high rises when the buffer fill reaches a fixed level.
// - tx_overflow is raised when a write arrives while the buffer is full.
// - tx_underflow_err pulses when the buffer runs dry inside a packet.
// - A packet leaves on the line with no idle slot between its words.
// - Write bandwidth must exceed line slot bandwidth on both sides.
// - Each serial lane has its own parity error strobe.
// - rx_high_error_rate_flag rises above one error in ten thousand bits.
// - Alignment markers are sent on the transmit side, one in every 16384 line slots.
// - Statistics leave as one-cycle strobes; counters live outside.
// - Loopback feeds the serial transmit lanes into the receive lanes.
`timescale 1ns/10ps
module mac_tx_flow_and_diagnostics #(
   parameter int DEPTH      = mac_tx_pkg::BUF_DEPTH,
   parameter int HIGH_LEVEL = mac_tx_pkg::BUF_HIGH_LEVEL,
   parameter int START      = mac_tx_pkg::BUF_START_LEVEL,
   parameter int LANES      = mac_tx_pkg::LANES,
   parameter int LANE_W     = mac_tx_pkg::LANE_W,
   parameter int AM_SPACING = mac_tx_pkg::AM_SPACING,
   parameter int BER_WINDOW = mac_tx_pkg::BER_WINDOW
) (
   input  wire logic                         clk,
   input  wire logic                         rstn,
   input  wire logic                         tx_ena,
   input  wire logic                         tx_sop,
   input  wire logic                         tx_eop,
   input  wire logic [LANES*LANE_W-1:0]      tx_data,
   output logic                              tx_buffer_high,
   output logic                              tx_overflow,
   output logic                              tx_underflow_err,
   input  wire logic                         line_slot,
   output logic                              line_valid,
   output logic                              line_sop,
   output logic                              line_eop,
   output logic                              line_abort,
   output logic                              line_marker,
   output logic [LANES*LANE_W-1:0]           line_data,
   output logic [LANES*(LANE_W+1)-1:0]       ser_tx_data,
   output logic                              ser_tx_valid,
   input  wire logic [LANES*(LANE_W+1)-1:0]  des_rx_data,
   input  wire logic                         des_rx_valid,
   input  wire logic                         loopback_pin,
   output logic                              stat_tx_packet,
   output logic [LANES-1:0]                  stat_rx_lane_parity_err,
   output logic                              rx_high_error_rate_flag
);
   import mac_tx_pkg::*;

   localparam int DW    = LANES * LANE_W;
   localparam int SW    = LANE_W + 1;
   localparam int WW    = DW + 2;
   localparam int AW    = $clog2(DEPTH);
   localparam int CW    = $clog2(DEPTH + 1);
   localparam int MW    = $clog2(AM_SPACING + 1);
   localparam int LIMIT = BER_WINDOW * LANES * LANE_W / BER_DEN;

   // Transmit buffer
   logic [WW-1:0]   mem [DEPTH];
   logic [AW-1:0]   wr_ptr;
   logic [AW-1:0]   next_wr_ptr;
   logic [AW-1:0]   rd_ptr;
   logic [AW-1:0]   next_rd_ptr;
   logic [CW-1:0]   fill;
   logic [CW-1:0]   next_fill;
   logic [CW-1:0]   eop_cnt;
   logic [CW-1:0]   next_eop_cnt;
   logic            wr_ok;
   logic            rd_en;
   logic [WW-1:0]   head;
   logic            head_sop;
   logic            head_eop;
   logic            buf_empty;
   logic            start_ok;

   // Line side
   line_state_t     state;
   line_state_t     next_state;
   logic [MW-1:0]   am_count;
   logic [MW-1:0]   next_am_count;
   logic            is_marker;
   logic            emit;
   logic            abort;
   logic            next_tx_buffer_high;
   logic            next_tx_overflow;
   logic            next_tx_underflow_err;
   logic            next_line_valid;
   logic            next_line_sop;
   logic            next_line_eop;
   logic            next_line_abort;
   logic            next_line_marker;
   logic [DW-1:0]   next_line_data;
   logic [LANES*SW-1:0] next_ser_tx_data;
   logic            next_ser_tx_valid;
   logic            next_stat_tx_packet;

   // Loopback pin synchroniser
   logic [SYNC_STAGES-1:0] lb_sync;
   logic            loopback;
   logic            next_loopback;

   assign head      = mem[rd_ptr];
   assign head_sop  = head[WW-1];
   assign head_eop  = head[WW-2];
   assign buf_empty = (fill == '0);

   always_comb begin
      logic [LANE_W-1:0] w;
      w = '0;
      // Full buffer refuses the word; user logic should have stopped
      wr_ok = tx_ena && (fill != CW'(DEPTH));
      // Start only with a whole packet queued or a deep enough backlog
      start_ok  = (eop_cnt != '0) || (fill >= CW'(START));
      is_marker = line_slot && (am_count == MW'(AM_SPACING));
      next_am_count = am_count;
      if (line_slot) begin
         next_am_count = is_marker ? '0 : MW'(am_count + MW'(1));
      end
      rd_en      = 1'b0;
      emit       = 1'b0;
      abort      = 1'b0;
      next_state = state;
      case (state)
         LINE_IDLE: begin
            if (line_slot && !is_marker && !buf_empty && start_ok) begin
               rd_en = 1'b1;
               // Stray words before a start are discarded
               emit  = head_sop;
               if (head_sop && !head_eop) begin
                  next_state = LINE_SEND;
               end
            end
         end
         LINE_SEND: begin
            if (line_slot && !is_marker) begin
               if (buf_empty) begin
                  // Writer paused mid-packet
                  abort      = 1'b1;
                  next_state = LINE_DROP;
               end else begin
                  rd_en = 1'b1;
                  emit  = 1'b1;
                  if (head_eop) begin
                     next_state = LINE_IDLE;
                  end
               end
            end
         end
         LINE_DROP: begin
            // Flush the rest of the broken packet without sending it
            if (!buf_empty) begin
               rd_en = 1'b1;
               if (head_eop) begin
                  next_state = LINE_IDLE;
               end
            end
         end
         default: begin
            next_state = LINE_IDLE;
         end
      endcase

      next_wr_ptr  = wr_ok ? AW'(wr_ptr + AW'(1)) : wr_ptr;
      next_rd_ptr  = rd_en ? AW'(rd_ptr + AW'(1)) : rd_ptr;
      next_fill    = CW'(fill + CW'(wr_ok) - CW'(rd_en));
      next_eop_cnt = CW'(eop_cnt + CW'(wr_ok && tx_eop)
                         - CW'(rd_en && head_eop));

      next_tx_buffer_high   = next_fill >= CW'(HIGH_LEVEL);
      // Sticky until reset so it cannot be missed
      next_tx_overflow      = tx_overflow || (tx_ena && !wr_ok);
      next_tx_underflow_err = abort;

      next_line_valid  = emit;
      next_line_sop    = emit && head_sop;
      next_line_eop    = emit && head_eop;
      next_line_abort  = abort;
      next_line_marker = is_marker;
      next_line_data   = emit ? head[DW-1:0] : '0;
      next_stat_tx_packet = emit && head_eop;

      next_ser_tx_valid = emit || is_marker;
      for (int i = 0; i < LANES; i++) begin
         w = is_marker ? MARKER_WORD[LANE_W-1:0]
             : (emit ? head[i*LANE_W +: LANE_W] : '0);
         next_ser_tx_data[i*SW +: SW] = {^w, w};
      end

      // Pin level accepted once the last two stages agree
      next_loopback = (lb_sync[1] == lb_sync[2]) ? lb_sync[2] : loopback;
   end

   always_ff @(posedge clk) begin
      if (wr_ok) begin
         mem[wr_ptr] <= {tx_sop, tx_eop, tx_data};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr           <= '0;
         rd_ptr           <= '0;
         fill             <= '0;
         eop_cnt          <= '0;
         state            <= LINE_IDLE;
         am_count         <= '0;
         tx_buffer_high   <= 1'b0;
         tx_overflow      <= 1'b0;
         tx_underflow_err <= 1'b0;
         line_valid       <= 1'b0;
         line_sop         <= 1'b0;
         line_eop         <= 1'b0;
         line_abort       <= 1'b0;
         line_marker      <= 1'b0;
         line_data        <= '0;
         ser_tx_data      <= '0;
         ser_tx_valid     <= 1'b0;
         stat_tx_packet   <= 1'b0;
         lb_sync          <= '0;
         loopback         <= 1'b0;
      end else begin
         wr_ptr           <= next_wr_ptr;
         rd_ptr           <= next_rd_ptr;
         fill             <= next_fill;
         eop_cnt          <= next_eop_cnt;
         state            <= next_state;
         am_count         <= next_am_count;
         tx_buffer_high   <= next_tx_buffer_high;
         tx_overflow      <= next_tx_overflow;
         tx_underflow_err <= next_tx_underflow_err;
         line_valid       <= next_line_valid;
         line_sop         <= next_line_sop;
         line_eop         <= next_line_eop;
         line_abort       <= next_line_abort;
         line_marker      <= next_line_marker;
         line_data        <= next_line_data;
         ser_tx_data      <= next_ser_tx_data;
         ser_tx_valid     <= next_ser_tx_valid;
         stat_tx_packet   <= next_stat_tx_packet;
         lb_sync          <= {lb_sync[SYNC_STAGES-2:0], loopback_pin};
         loopback         <= next_loopback;
      end
   end

   // Receive lanes: deserializer or the local transmit lanes
   lane_if #(.W(LANE_W)) lane [LANES] ();
   logic [LANES-1:0] lane_err;

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane[g].data  = loopback ? ser_tx_data[g*SW +: LANE_W]
                                      : des_rx_data[g*SW +: LANE_W];
      assign lane[g].par   = loopback ? ser_tx_data[g*SW + LANE_W]
                                      : des_rx_data[g*SW + LANE_W];
      assign lane[g].valid = loopback ? ser_tx_valid : des_rx_valid;
      assign lane_err[g]   = lane[g].err;
      assign stat_rx_lane_parity_err[g] = lane[g].err;

      lane_parity_check u_check (
         .clk  (clk),
         .rstn (rstn),
         .lane (lane[g].chk)
      );
   end

   hi_ber_monitor #(
      .LANES  (LANES),
      .WINDOW (BER_WINDOW),
      .LIMIT  (LIMIT)
   ) u_hi_ber (
      .clk       (clk),
      .rstn      (rstn),
      .lane_err  (lane_err),
      .high_rate (rx_high_error_rate_flag)
   );
endmodule : mac_tx_flow_and_diagnostics

// *** tb/mac_tx_flow_and_diagnostics_properties.sv ***
`timescale 1ns/10ps
module mac_tx_props #(
   parameter int LANES  = 4,
   parameter int LANE_W = 16,
   parameter int SW     = LANES*(LANE_W+1)
) (
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic             tx_buffer_high,
   input wire logic             tx_overflow,
   input wire logic             tx_underflow_err,
   input wire logic             line_slot,
   input wire logic             line_valid,
   input wire logic             line_sop,
   input wire logic             line_eop,
   input wire logic             line_abort,
   input wire logic             line_marker,
   input wire logic [SW-1:0]    ser_tx_data,
   input wire logic             ser_tx_valid,
   input wire logic [SW-1:0]    des_rx_data,
   input wire logic             des_rx_valid,
   input wire logic             loopback_pin,
   input wire logic             stat_tx_packet,
   input wire logic [LANES-1:0] stat_rx_lane_parity_err
);
   import mac_tx_pkg::*;
   logic             in_pkt;
   logic             next_in_pkt;
   logic [LANES-1:0] par_bad;

   // Open from a sop word on the line until its eop or an abort
   always_comb begin
      next_in_pkt = in_pkt;
      if (line_valid && line_sop)
         next_in_pkt = 1'b1;
      if ((line_valid && line_eop) || line_abort)
         next_in_pkt = 1'b0;
      for (int i = 0; i < LANES; i++)
         par_bad[i] = des_rx_valid
                      && ^des_rx_data[i*(LANE_W+1) +: LANE_W+1];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         in_pkt <= 1'b0;
      else
         in_pkt <= next_in_pkt;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_pkt_strobe: assert property
      (stat_tx_packet == (line_valid && line_eop))
      else $error("packet strobe apart from last word");
   a_ovf_sticky: assert property (tx_overflow |=> tx_overflow)
      else $error("overflow flag dropped");
   a_under_abort: assert property (tx_underflow_err == line_abort)
      else $error("underflow and abort disagree");
   a_under_pulse: assert property
      (tx_underflow_err |=> !tx_underflow_err)
      else $error("underflow longer than one cycle");
   a_line_cause: assert property
      ((line_valid || line_marker || line_abort) |-> $past(line_slot))
      else $error("line word without a slot");
   a_no_gap: assert property
      (in_pkt && $past(line_slot)
       |-> line_valid || line_marker || line_abort)
      else $error("idle slot inside a packet");
   a_marker_word: assert property
      (line_marker |-> !line_valid
       && ser_tx_data == {LANES{^MARKER_WORD, MARKER_WORD}})
      else $error("marker slot content wrong");
   a_ser_valid: assert property
      (ser_tx_valid == (line_valid || line_marker))
      else $error("serial valid mismatch");
   a_lane_parity: assert property
      (!loopback_pin && !$past(loopback_pin, 5)
       |-> stat_rx_lane_parity_err == $past(par_bad))
      else $error("lane parity strobe wrong");

   c_overflow: cover property ($rose(tx_overflow));
   c_underflow: cover property (tx_underflow_err);
   c_marker: cover property (line_marker);
   c_high: cover property ($rose(tx_buffer_high));
endmodule : mac_tx_props

bind mac_tx_flow_and_diagnostics mac_tx_props #(
   .LANES(LANES), .LANE_W(LANE_W)
) mac_tx_props_inst (
   .clk(clk), .rstn(rstn), .tx_buffer_high(tx_buffer_high),
   .tx_overflow(tx_overflow), .tx_underflow_err(tx_underflow_err),
   .line_slot(line_slot), .line_valid(line_valid), .line_sop(line_sop),
   .line_eop(line_eop), .line_abort(line_abort),
   .line_marker(line_marker), .ser_tx_data(ser_tx_data),
   .ser_tx_valid(ser_tx_valid), .des_rx_data(des_rx_data),
   .des_rx_valid(des_rx_valid), .loopback_pin(loopback_pin),
   .stat_tx_packet(stat_tx_packet),
   .stat_rx_lane_parity_err(stat_rx_lane_parity_err)
);

// *** tb/user_logic_model.sv ***
`timescale 1ns/10ps
module user_logic_model (
   input  wire logic                                       clk,
   input  wire logic                                       tx_buffer_high,
   output logic                                            tx_ena,
   output logic                                            tx_sop,
   output logic                                            tx_eop,
   output logic [mac_tx_pkg::LANES*mac_tx_pkg::LANE_W-1:0] tx_data
);
   import mac_tx_pkg::*;
   initial begin
      tx_ena = 1'b0;
      tx_sop = 1'b0;
      tx_eop = 1'b0;
      tx_data = '0;
   end

   // Writes one packet; a stall after word stall_at or ign set
   // breaks the write rules on purpose
   task automatic send(input int len, input int stall_at, input bit ign);
      for (int i = 0; i < len; i++) begin
         for (int w = 0; w < 400 && tx_buffer_high === 1'b1 && !ign;
              w++) begin
            tx_ena = 1'b0;
            tx_data = ~tx_data;
            @(negedge clk);
         end
         tx_ena = 1'b1;
         tx_sop = (i == 0);
         tx_eop = (i == len - 1);
         tx_data = {LANES{LANE_W'(32'h100 + i)}};
         @(negedge clk);
         if (i == stall_at) begin
            tx_ena = 1'b0;
            tx_data = ~tx_data;
            repeat (40) @(negedge clk);
         end
      end
      tx_ena = 1'b0;
      tx_sop = 1'b0;
      tx_eop = 1'b0;
      tx_data = ~tx_data;
   endtask : send
endmodule : user_logic_model

// *** tb/mac_tx_flow_and_diagnostics_tb_top.sv ***
`timescale 1ns/10ps
module mac_tx_flow_and_diagnostics_tb_top;
   import mac_tx_pkg::*;
   localparam int DW  = LANES*LANE_W;
   localparam int SW  = LANES*(LANE_W+1);
   localparam int AMS = 7;
   logic             clk, rstn, tx_ena, tx_sop, tx_eop, line_slot;
   logic             des_rx_valid, loopback_pin, tx_buffer_high;
   logic             tx_overflow, tx_underflow_err, line_valid, line_sop;
   logic             line_eop, line_abort, line_marker, ser_tx_valid;
   logic             stat_tx_packet, rx_high_error_rate_flag;
   logic [DW-1:0]    tx_data, line_data;
   logic [SW-1:0]    ser_tx_data, des_rx_data;
   logic [LANES-1:0] stat_rx_lane_parity_err;
   logic [DW-1:0]    got[$];
   int               failures, checked, n_slot, n_mark, n_eop;
   int               n_under, n_perr, n_word;

   mac_tx_flow_and_diagnostics #(
      .AM_SPACING(AMS), .BER_WINDOW(16)
   ) mac_tx_flow_and_diagnostics_inst (
      .clk(clk), .rstn(rstn), .tx_ena(tx_ena), .tx_sop(tx_sop),
      .tx_eop(tx_eop), .tx_data(tx_data), .tx_buffer_high(tx_buffer_high),
      .tx_overflow(tx_overflow), .tx_underflow_err(tx_underflow_err),
      .line_slot(line_slot), .line_valid(line_valid), .line_sop(line_sop),
      .line_eop(line_eop), .line_abort(line_abort),
      .line_marker(line_marker), .line_data(line_data),
      .ser_tx_data(ser_tx_data), .ser_tx_valid(ser_tx_valid),
      .des_rx_data(des_rx_data), .des_rx_valid(des_rx_valid),
      .loopback_pin(loopback_pin), .stat_tx_packet(stat_tx_packet),
      .stat_rx_lane_parity_err(stat_rx_lane_parity_err),
      .rx_high_error_rate_flag(rx_high_error_rate_flag)
   );
   user_logic_model user_logic_model_inst (
      .clk(clk), .tx_buffer_high(tx_buffer_high), .tx_ena(tx_ena),
      .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_data(tx_data)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (rstn && line_slot) n_slot++;
   // Line observer, sampled mid-cycle once outputs have settled
   always @(negedge clk) begin
      if (line_valid === 1'b1) got.push_back(line_data);
      n_word = got.size();
      if (line_marker === 1'b1) n_mark++;
      if (stat_tx_packet === 1'b1) n_eop++;
      if (tx_underflow_err === 1'b1) n_under++;
      if (stat_rx_lane_parity_err !== '0) n_perr++;
   end

   task automatic final_report();
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         failures++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic timeout();
      failures++;
      $display("Error at %0t: wait ran out", $time);
      final_report();
   endtask : timeout
   task automatic wait_cnt(ref int cnt, input int want);
      for (int i = 0; i < 300; i++) begin
         if (cnt >= want) return;
         @(negedge clk);
      end
      timeout();
   endtask : wait_cnt
   task automatic wait_flag(input logic want);
      for (int i = 0; i < 80; i++) begin
         if (rx_high_error_rate_flag === want) return;
         @(negedge clk);
      end
      timeout();
   endtask : wait_flag
   function automatic logic [SW-1:0] rx_word(input logic [LANES-1:0] bad);
      logic [SW-1:0] v;
      for (int i = 0; i < LANES; i++)
         v[i*(LANE_W+1) +: LANE_W+1] = {^LANE_W'(i+5) ^ bad[i], LANE_W'(i+5)};
      return v;
   endfunction : rx_word
   task automatic do_reset();
      rstn = 1'b0;
      line_slot = 1'b0;
      loopback_pin = 1'b0;
      des_rx_valid = 1'b0;
      repeat (2) @(negedge clk);
      {n_slot, n_mark, n_eop, n_under, n_perr} = '0;
      got.delete();
      rstn = 1'b1;
   endtask : do_reset

   task automatic t_stream();
      do_reset();
      line_slot = 1'b1;
      user_logic_model_inst.send(20, -1, 1'b0);
      wait_cnt(n_word, 20);
      repeat (3) @(negedge clk);
      line_slot = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 20; i++)
         check(got[i] === {LANES{LANE_W'(32'h100 + i)}}, "word order");
      check(n_eop === 1, "packet strobe count");
      check(n_mark === n_slot / (AMS + 1), "marker spacing");
   endtask : t_stream
   task automatic t_flow();
      do_reset();
      user_logic_model_inst.send(BUF_HIGH_LEVEL - 1, -1, 1'b0);
      repeat (2) @(negedge clk);
      check(tx_buffer_high === 1'b0, "high flag early");
      user_logic_model_inst.send(1, -1, 1'b0);
      repeat (2) @(negedge clk);
      check(tx_buffer_high === 1'b1, "high flag missing");
      fork
         user_logic_model_inst.send(9, -1, 1'b0);
         begin
            repeat (20) @(negedge clk);
            line_slot = 1'b1;
         end
      join
      wait_cnt(n_word, BUF_HIGH_LEVEL + 9);
      check(tx_overflow === 1'b0, "overflow while flag kept");
      check(tx_buffer_high === 1'b0, "high flag stuck");
   endtask : t_flow
   task automatic t_overflow();
      do_reset();
      user_logic_model_inst.send(BUF_DEPTH, -1, 1'b1);
      check(tx_overflow === 1'b0, "overflow at full");
      // One idle edge so the write strobe is not raised again at once
      @(negedge clk);
      user_logic_model_inst.send(1, -1, 1'b1);
      @(negedge clk);
      check(tx_overflow === 1'b1, "overflow missing");
      line_slot = 1'b1;
      repeat (40) @(negedge clk);
      check(tx_overflow === 1'b1, "overflow lost");
      do_reset();
      check(tx_overflow === 1'b0, "overflow kept by reset");
   endtask : t_overflow
   task automatic t_underflow();
      do_reset();
      line_slot = 1'b1;
      user_logic_model_inst.send(20, 17, 1'b0);
      repeat (5) @(negedge clk);
      check(n_under === 1, "underflow count");
      check(n_eop === 0, "cut packet completed");
   endtask : t_underflow
   task automatic t_parity();
      do_reset();
      des_rx_valid = 1'b1;
      des_rx_data = rx_word('0);
      repeat (20) @(negedge clk);
      check(rx_high_error_rate_flag === 1'b0, "flag with no errors");
      des_rx_data = rx_word(4'h4);
      @(negedge clk);
      des_rx_data = rx_word('0);
      check(stat_rx_lane_parity_err === 4'h4, "lane strobe");
      @(negedge clk);
      check(stat_rx_lane_parity_err === '0, "strobe too long");
      wait_flag(1'b1);
      wait_flag(1'b0);
   endtask : t_parity
   task automatic t_loopback();
      do_reset();
      loopback_pin = 1'b1;
      repeat (6) @(negedge clk);
      des_rx_valid = 1'b1;
      des_rx_data = rx_word('1);
      line_slot = 1'b1;
      user_logic_model_inst.send(12, -1, 1'b0);
      wait_cnt(n_word, 12);
      repeat (3) @(negedge clk);
      check(n_perr === 0, "far lanes used in loopback");
      loopback_pin = 1'b0;
      repeat (6) @(negedge clk);
      check(stat_rx_lane_parity_err === '1, "far lanes not back");
   endtask : t_loopback

   initial begin
      des_rx_data = '0;
      t_stream();
      t_flow();
      t_overflow();
      t_underflow();
      t_parity();
      t_loopback();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      timeout();
   end
endmodule : mac_tx_flow_and_diagnostics_tb_top
